// *** rtl/nslm_monitor.sv ***
/*
  Near-position and speed-limit monitor: position error window flag,
  torque-control speed limit selection and limit-active flag, with a
  Wishbone classic register slave and a masked interrupt.
  Assumes position, speed and torque-mode inputs come from logic on
  i_clock; the host runs one request at a time.
*/
// Added by the designer: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module nslm_monitor
  import nslm_pkg::*;
(
  input  wire logic        i_clock,        // 125 MHz system clock
  input  wire logic        i_rst_n,        // synchronous reset, low
  input  wire logic        i_clk_en,       // freezes all state when low
  input  wire logic        i_wb_cyc,       // bus cycle
  input  wire logic        i_wb_stb,       // bus strobe
  input  wire logic        i_wb_we,        // write enable
  input  wire logic [7:0]  i_wb_adr,       // byte address
  input  wire logic [3:0]  i_wb_sel,       // byte enables
  input  wire logic [31:0] i_wb_dat,       // write data
  output var  logic [31:0] o_wb_dat,       // read data
  output var  logic        o_wb_ack,       // acknowledge
  input  wire logic [31:0] i_pos_ref,      // commanded reference count
  input  wire logic [31:0] i_pos_fb,       // actual travel count
  input  wire logic [15:0] i_motor_speed,  // signed motor speed, rpm
  input  wire logic        i_torque_ctrl,  // torque control active
  output var  logic        o_near,         // allocated near flag
  output var  logic        o_vlt,          // allocated limit flag
  output var  logic [15:0] o_speed_limit,  // applied limit, rpm
  output var  logic        o_irq           // interrupt, high level
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic        ack;
    logic [31:0] rdat;
    logic        near_alloc;
    logic        vlt_alloc;
    nslm_mode_e  mode_pend;
    nslm_mode_e  mode_act;
    logic        src_pend;
    logic        src_act;
    logic [30:0] near_w;
    logic [15:0] trq_lim;
    logic [15:0] motor_max;
    logic [15:0] overspd;
    logic [15:0] ext_lim;
    logic [3:0]  irq_mask;
    logic        near_raw;
    logic        vlt_raw;
    logic        near_out;
    logic        vlt_out;
    logic        irq;
    logic [15:0] limit;
  } nslm_core_s;

  localparam nslm_core_s CORE_RST = '{
    ack: 1'b0, rdat: '0, near_alloc: 1'b0, vlt_alloc: 1'b0,
    mode_pend: NSLM_INTERNAL, mode_act: NSLM_INTERNAL,
    src_pend: 1'b0, src_act: 1'b0, near_w: NEAR_W_MAX,
    trq_lim: TRQ_LIM_MAX, motor_max: MOTOR_MAX_RST,
    overspd: OVERSPD_RST, ext_lim: EXT_LIM_RST, irq_mask: '0,
    near_raw: 1'b0, vlt_raw: 1'b0, near_out: 1'b0, vlt_out: 1'b0,
    irq: 1'b0, limit: MOTOR_MAX_RST};

  nslm_core_s r;
  nslm_core_s next_r;

  logic [IRQ_N-1:0] irq_set;
  logic [IRQ_N-1:0] irq_clr;
  logic [IRQ_N-1:0] irq_stat;
  logic [32:0]      err;
  logic [32:0]      err_mag;
  logic [15:0]      spd_mag;
  logic [15:0]      lim_cap;
  logic [15:0]      lim_int;
  logic [7:0]       adr_word;
  logic             req_new;
  logic             wr_go;
  logic [31:0]      wmask;
  logic             restart_go;

  // byte-lane merge of a write into the current register value
  function automatic logic [31:0] nslm_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [31:0] m);
    nslm_merge = (old & ~m) | (wd & m);
  endfunction

  // ****************************************************************
  // bus decode
  // ****************************************************************
  // the write lands on the edge where the master sees ack, so a held
  // request is never applied twice
  always_comb begin
    adr_word = {i_wb_adr[7:2], 2'b00};
    req_new  = i_wb_cyc && i_wb_stb && !r.ack;
    wr_go    = i_wb_cyc && i_wb_stb && i_wb_we && r.ack;
    wmask    = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}},
                {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
    restart_go = wr_go && (adr_word == ADR_CTRL) && i_wb_sel[0]
                 && i_wb_dat[CTL_RESTART];
  end

  // ****************************************************************
  // position window and speed magnitude
  // ****************************************************************
  // sign-extended difference cannot overflow, then take magnitude
  always_comb begin
    err     = {i_pos_ref[31], i_pos_ref} - {i_pos_fb[31], i_pos_fb};
    err_mag = err[32] ? 33'(-err) : err;                 // R13
    spd_mag = i_motor_speed[15] ? 16'(-i_motor_speed)
                                : i_motor_speed;
  end

  // ****************************************************************
  // internal limit
  // ****************************************************************
  // the ceiling replaces a torque limit set above it
  always_comb begin
    lim_cap = r.src_act ? r.overspd : r.motor_max;       // R8 R9 R12
    lim_int = (r.trq_lim < lim_cap) ? r.trq_lim : lim_cap; // R9 R12
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic [31:0] v;  // merged write value of the addressed register
    v = '0;
    next_r = r;

    // single-cycle ack, dropped the cycle after it was given
    next_r.ack = req_new;
    if (req_new) begin
      unique case (adr_word)
        ADR_CTRL: begin
          next_r.rdat = '0;
          next_r.rdat[CTL_NEAR_ALLOC] = r.near_alloc;
          next_r.rdat[CTL_VLT_ALLOC]  = r.vlt_alloc;
          next_r.rdat[CTL_MODE_SEL]   = r.mode_pend;
          next_r.rdat[CTL_SRC_SEL]    = r.src_pend;
        end
        ADR_NEAR_W:    next_r.rdat = {1'b0, r.near_w};
        ADR_TRQ_LIM:   next_r.rdat = {16'h0000, r.trq_lim};
        ADR_MOTOR_MAX: next_r.rdat = {16'h0000, r.motor_max};
        ADR_OVERSPD:   next_r.rdat = {16'h0000, r.overspd};
        ADR_EXT_LIM:   next_r.rdat = {16'h0000, r.ext_lim};
        ADR_STATUS: begin
          next_r.rdat = '0;
          next_r.rdat[ST_NEAR] = r.near_raw;
          next_r.rdat[ST_VLT]  = r.vlt_raw;
          next_r.rdat[ST_MODE] = r.mode_act;
          next_r.rdat[ST_SRC]  = r.src_act;
          next_r.rdat[ST_LIMIT_LSB +: 16] = r.limit;
        end
        ADR_IRQ_STAT:  next_r.rdat = {28'h0000000, irq_stat};
        ADR_IRQ_MASK:  next_r.rdat = {28'h0000000, r.irq_mask};
        default:       next_r.rdat = '0;  // unmapped reads as zero
      endcase
    end

    // register writes; selectors only stage, restart applies them
    if (wr_go) begin
      unique case (adr_word)
        ADR_CTRL: begin
          if (i_wb_sel[0]) begin
            next_r.near_alloc = i_wb_dat[CTL_NEAR_ALLOC];
            next_r.vlt_alloc  = i_wb_dat[CTL_VLT_ALLOC];
            next_r.mode_pend  = nslm_mode_e'(i_wb_dat[CTL_MODE_SEL]);
            next_r.src_pend   = i_wb_dat[CTL_SRC_SEL];
          end
        end
        ADR_NEAR_W: begin
          // out-of-range widths are clamped into 1..max
          v = nslm_merge({1'b0, r.near_w}, i_wb_dat, wmask);
          if (v > {1'b0, NEAR_W_MAX}) begin
            next_r.near_w = NEAR_W_MAX;                  // R2
          end else if (v == 32'h00000000) begin
            next_r.near_w = NEAR_W_MIN;                  // R2
          end else begin
            next_r.near_w = v[30:0];                     // R2
          end
        end
        ADR_TRQ_LIM: begin
          v = nslm_merge({16'h0000, r.trq_lim}, i_wb_dat, wmask);
          next_r.trq_lim = (v > {16'h0000, TRQ_LIM_MAX})
                           ? TRQ_LIM_MAX : v[15:0];      // R7
        end
        ADR_MOTOR_MAX: begin
          v = nslm_merge({16'h0000, r.motor_max}, i_wb_dat, wmask);
          next_r.motor_max = v[15:0];
        end
        ADR_OVERSPD: begin
          v = nslm_merge({16'h0000, r.overspd}, i_wb_dat, wmask);
          next_r.overspd = v[15:0];
        end
        ADR_EXT_LIM: begin
          v = nslm_merge({16'h0000, r.ext_lim}, i_wb_dat, wmask);
          next_r.ext_lim = v[15:0];
        end
        ADR_IRQ_MASK: begin
          if (i_wb_sel[0]) begin
            next_r.irq_mask = i_wb_dat[IRQ_N-1:0];
          end
        end
        default: ;  // status, irq status and holes take no store
      endcase
    end

    // restart takes the staged selectors; staged bits written in the
    // same request are the ones applied
    if (restart_go) begin
      next_r.mode_act = next_r.mode_pend;                // R6
      next_r.src_act  = next_r.src_pend;                 // R9
    end

    // window flag, width takes effect the cycle after it is written
    next_r.near_raw = err_mag < {2'b00, r.near_w};       // R1 R13
    next_r.near_out = next_r.near_raw && r.near_alloc;   // R4

    // applied limit: host value in external mode, else internal
    next_r.limit = (r.mode_act == NSLM_EXTERNAL)
                   ? r.ext_lim : lim_int;                // R10 R7
    // flag only while torque control is clamping at the limit
    next_r.vlt_raw = i_torque_ctrl && (spd_mag >= r.limit); // R5
    next_r.vlt_out = next_r.vlt_raw && r.vlt_alloc;      // R11

    // level interrupt lags status by one cycle to come from a flop
    next_r.irq = |(irq_stat & r.irq_mask);
  end

  // ****************************************************************
  // events and sticky status
  // ****************************************************************
  always_comb begin
    irq_set[IRQ_NEAR_ON]  = next_r.near_raw && !r.near_raw;
    irq_set[IRQ_NEAR_OFF] = !next_r.near_raw && r.near_raw;
    irq_set[IRQ_VLT_ON]   = next_r.vlt_raw && !r.vlt_raw;
    irq_set[IRQ_VLT_OFF]  = !next_r.vlt_raw && r.vlt_raw;
    irq_clr = (wr_go && adr_word == ADR_IRQ_STAT && i_wb_sel[0])
              ? i_wb_dat[IRQ_N-1:0] : '0;
  end

  for (genvar g = 0; g < IRQ_N; g++) begin : g_irq
    nslm_irq_bit u_bit (
      .i_clock  (i_clock),
      .i_rst_n  (i_rst_n),
      .i_clk_en (i_clk_en),
      .i_set    (irq_set[g]),
      .i_clr    (irq_clr[g]),
      .o_flag   (irq_stat[g])
    );
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  // reset wins over the clock enable so a frozen block still resets
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      r <= CORE_RST;
    end else if (i_clk_en) begin
      r <= next_r;
    end
  end

  // outputs straight from flops
  assign o_wb_ack      = r.ack;
  assign o_wb_dat      = r.rdat;
  assign o_near        = r.near_out;
  assign o_vlt         = r.vlt_out;
  assign o_speed_limit = r.limit;
  assign o_irq         = r.irq;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  a_near_window: assert property ( // R1
    i_clk_en && r.near_alloc |=>
      o_near == ($past(err_mag) < {2'b00, $past(r.near_w)}))
    else $error("near flag disagrees with window compare");

  a_near_width_range: assert property ( // R2
    r.near_w >= NEAR_W_MIN && r.near_w <= NEAR_W_MAX)
    else $error("near width left its range");

  a_near_unalloc: assert property ( // R4
    !r.near_alloc ##1 !r.near_alloc |-> !o_near)
    else $error("near output driven without allocation");

  a_vlt_reached: assert property ( // R5
    i_clk_en && r.vlt_alloc && i_torque_ctrl &&
    spd_mag >= o_speed_limit |=> o_vlt)
    else $error("limit flag missing at limit speed");

  a_vlt_release: assert property ( // R5
    i_clk_en && !i_torque_ctrl |=> !o_vlt)
    else $error("limit flag held outside torque control");

  a_mode_restart: assert property ( // R6
    i_clk_en && !restart_go |=> $stable(r.mode_act) && $stable(r.src_act))
    else $error("limit source changed without restart");

  a_trq_range: assert property ( // R7
    r.trq_lim <= TRQ_LIM_MAX)
    else $error("torque limit above its range");

  a_src0_limit: assert property ( // R12
    i_clk_en && r.mode_act == NSLM_INTERNAL && !r.src_act |=>
      o_speed_limit == (($past(r.trq_lim) < $past(r.motor_max))
                        ? $past(r.trq_lim) : $past(r.motor_max)))
    else $error("internal limit is not min of motor max");

  a_src1_limit: assert property ( // R9
    i_clk_en && r.mode_act == NSLM_INTERNAL && r.src_act |=>
      o_speed_limit <= $past(r.overspd) &&
      o_speed_limit <= $past(r.trq_lim))
    else $error("limit exceeds overspeed or setting");

  a_ext_limit: assert property ( // R10
    i_clk_en && r.mode_act == NSLM_EXTERNAL |=>
      o_speed_limit == $past(r.ext_lim))
    else $error("external limit not applied");

  a_vlt_unalloc: assert property ( // R11
    !r.vlt_alloc ##1 !r.vlt_alloc |-> !o_vlt)
    else $error("limit output driven without allocation");

  a_ack_single: assert property (
    o_wb_ack && i_clk_en |=> !o_wb_ack)
    else $error("ack held beyond one cycle");

  c_near_enter: cover property (!o_near ##1 o_near);
  c_vlt_active: cover property (!o_vlt ##1 o_vlt);
  c_restart_ext: cover property (restart_go ##1
                                 r.mode_act == NSLM_EXTERNAL);
  c_irq_raise: cover property (!o_irq ##1 o_irq);

endmodule
`default_nettype wire

// *** rtl/nslm_pkg.sv ***
/*
  Constants, register map and state types of the near-position and
  speed-limit monitor.
  Assumes one 125 MHz clock and a classic Wishbone slave port with
  32-bit data; speeds are in rpm, positions in reference units.
*/
// Contract
// R1: near flag while position error below width
// R2: near width 1..1073741824, default max, immediate
// R3: host should set near width above completed width
// R4: near flag drives output only when allocated
// R5: limit flag while speed reaches applied limit
// R6: mode selector internal/external, applies after restart
// R7: torque limit 0..10000 rpm, default 10000, immediate
// R8: oversized torque limit replaced by motor ceiling
// R9: source one uses min of overspeed and limit
// R10: external mode uses host supplied limit value
// R11: limit flag drives output only when allocated
// R12: source zero uses min of motor max, limit
// R13: position error compared by magnitude
package nslm_pkg;

  // ****************************************************************
  // register byte addresses
  // ****************************************************************
  localparam logic [7:0] ADR_CTRL      = 8'h00;
  localparam logic [7:0] ADR_NEAR_W    = 8'h04;
  localparam logic [7:0] ADR_TRQ_LIM   = 8'h08;
  localparam logic [7:0] ADR_MOTOR_MAX = 8'h0C;
  localparam logic [7:0] ADR_OVERSPD   = 8'h10;
  localparam logic [7:0] ADR_EXT_LIM   = 8'h14;
  localparam logic [7:0] ADR_STATUS    = 8'h18;
  localparam logic [7:0] ADR_IRQ_STAT  = 8'h1C;
  localparam logic [7:0] ADR_IRQ_MASK  = 8'h20;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CTL_NEAR_ALLOC = 0;
  localparam int CTL_VLT_ALLOC  = 1;
  localparam int CTL_MODE_SEL   = 2;
  localparam int CTL_SRC_SEL    = 3;
  localparam int CTL_RESTART    = 4;
  localparam int ST_NEAR        = 0;
  localparam int ST_VLT         = 1;
  localparam int ST_MODE        = 2;
  localparam int ST_SRC         = 3;
  localparam int ST_LIMIT_LSB   = 16;
  localparam int IRQ_NEAR_ON    = 0;
  localparam int IRQ_NEAR_OFF   = 1;
  localparam int IRQ_VLT_ON     = 2;
  localparam int IRQ_VLT_OFF    = 3;
  localparam int IRQ_N          = 4;

  // ****************************************************************
  // ranges and reset values
  // ****************************************************************
  localparam logic [30:0] NEAR_W_MIN    = 31'h00000001;
  localparam logic [30:0] NEAR_W_MAX    = 31'h40000000;
  localparam logic [15:0] TRQ_LIM_MAX   = 16'h2710;
  localparam logic [15:0] MOTOR_MAX_RST = 16'h1770;
  localparam logic [15:0] OVERSPD_RST   = 16'h1C20;
  localparam logic [15:0] EXT_LIM_RST   = 16'h2710;

  // limit mode: type of the staged and active mode selectors, which reset to NSLM_INTERNAL
  typedef enum logic {NSLM_INTERNAL, NSLM_EXTERNAL} nslm_mode_e;

endpackage

// *** rtl/nslm_irq_bit.sv ***
/*
  One sticky interrupt status bit with write-one-to-clear.
  Assumes set and clear come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module nslm_irq_bit
  import nslm_pkg::*;
(
  input  wire logic i_clock,   // system clock
  input  wire logic i_rst_n,   // synchronous reset, active low
  input  wire logic i_clk_en,  // freezes the bit while low
  input  wire logic i_set,     // event pulse
  input  wire logic i_clr,     // software write of one
  output var  logic o_flag     // sticky status
);

  typedef struct packed {
    logic flag;
  } nslm_bit_s;

  nslm_bit_s r;
  nslm_bit_s next_r;

  // set beats clear so an event in the clearing cycle is kept
  always_comb begin
    next_r = r;
    if (i_set) begin
      next_r.flag = 1'b1;
    end else if (i_clr) begin
      next_r.flag = 1'b0;
    end
  end

  // state register
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      r <= '0;
    end else if (i_clk_en) begin
      r <= next_r;
    end
  end

  assign o_flag = r.flag;

endmodule
`default_nettype wire

// *** testbench/nslm_host_model.sv ***
/*
  Host-side partner: drives position counts, motor speed and the
  torque-control state into the monitor.
  Assumes the bench sets the wanted error, speed and state by
  non-blocking assignment at a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module nslm_host_model (
  input  wire logic        i_clock,    // system clock
  input  wire logic [31:0] i_err,      // wanted reference minus travel
  input  wire logic [15:0] i_spd,      // wanted signed speed
  input  wire logic        i_trq,      // wanted torque control state
  output var  logic [31:0] o_pos_ref,  // commanded reference count
  output var  logic [31:0] o_pos_fb,   // actual travel count
  output var  logic [15:0] o_speed,    // motor speed
  output var  logic        o_trq       // torque control running
);
  logic [31:0] base;  // moving offset of both counts

  // known values before the first edge
  initial begin
    base      = 32'h00000000;
    o_pos_ref = 32'h00000000;
    o_pos_fb  = 32'h00000000;
    o_speed   = 16'h0000;
    o_trq     = 1'b0;
  end

  // both counts move every edge, so only their difference is stable;
  // a design that looks at one count alone cannot pass
  always @(posedge i_clock) begin
    base      <= base + 32'h01234567;
    o_pos_fb  <= base;
    o_pos_ref <= base + i_err;
    o_speed   <= i_spd;
    o_trq     <= i_trq;
  end
endmodule
`default_nettype wire

// *** testbench/nslm_monitor_tb_top.sv ***
/*
  Self-checking bench of the near-position and speed-limit monitor.
  Assumes the register map and reset values of nslm_pkg and the
  one-cycle Wishbone answer of the design.
*/
`timescale 1ns/1ps
`default_nettype none
module nslm_monitor_tb_top
  import nslm_pkg::*;
  ;
  typedef struct {string nm; int sel; logic [31:0] exp;} nslm_note_s;
  logic        i_clock, rst_n, clk_en, cyc, stb, we, ack, near, vlt, irq;
  logic        trq, trq_w;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat, rdat, pos_ref, pos_fb, err;
  logic [15:0] speed, spd, lim, rnd;
  nslm_note_s  rd_q[$], ob_q[$], nt;
  int          mismatches, total_checks, cycles, e;

  nslm_host_model host (.i_clock(i_clock), .i_err(err), .i_spd(spd),
    .i_trq(trq_w), .o_pos_ref(pos_ref), .o_pos_fb(pos_fb),
    .o_speed(speed), .o_trq(trq));
  nslm_monitor uut (.i_clock(i_clock), .i_rst_n(rst_n),
    .i_clk_en(clk_en), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
    .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat), .o_wb_dat(rdat),
    .o_wb_ack(ack), .i_pos_ref(pos_ref), .i_pos_fb(pos_fb),
    .i_motor_speed(speed), .i_torque_ctrl(trq), .o_near(near),
    .o_vlt(vlt), .o_speed_limit(lim), .o_irq(irq));

  // ****************************************************************
  // checking and bus tasks
  // ****************************************************************
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // one classic cycle; the request holds until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge i_clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    sel <= 4'hF;
    adr <= a;
    dat <= d;
    // no own limit: only the cycle guard ends a hung wait
    do begin
      @(posedge i_clock);
    end while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
    sel <= 4'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input string nm);
    rd_q.push_back('{nm, 0, x});
    wb(1'b0, a, 32'h00000000);
  endtask

  // let model, design and irq lag settle, then note what must show
  task automatic look(input int s, input logic [31:0] x,
                      input string nm);
    repeat (5) @(posedge i_clock);
    ob_q.push_back('{nm, s, x});
    @(posedge i_clock);
  endtask

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  // ****************************************************************
  // output watcher: compares settled outputs at the falling edge
  // ****************************************************************
  always @(negedge i_clock) begin
    if (ack === 1'b1 && we === 1'b0 && rd_q.size() > 0) begin
      nt = rd_q.pop_front();
      check(nt.nm, rdat, nt.exp);
    end
    while (ob_q.size() > 0) begin
      nt = ob_q.pop_front();
      case (nt.sel)
        0: check(nt.nm, {31'h0, near}, nt.exp);
        1: check(nt.nm, {31'h0, vlt}, nt.exp);
        2: check(nt.nm, {31'h0, irq}, nt.exp);
        default: check(nt.nm, {16'h0, lim}, nt.exp);
      endcase
    end
  end

  // clock and hang guard
  initial begin
    i_clock = 1'b0;
    forever #4 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    {rst_n, cyc, stb, we, trq_w} = 5'h00;
    clk_en = 1'b1;
    adr = 8'h00;
    sel = 4'h0;
    dat = 32'h00000000;
    err = 32'h50000000;
    spd = 16'h0000;
    rnd = 16'h0030;
    repeat (12) @(posedge i_clock);
    rst_n <= 1'b1;
    rd(ADR_CTRL, 32'h00000000, "ctrl");
    rd(ADR_NEAR_W, 32'h40000000, "near_w");
    rd(ADR_TRQ_LIM, 32'h00002710, "trq_lim");
    rd(ADR_MOTOR_MAX, 32'h00001770, "motor_max");
    rd(ADR_OVERSPD, 32'h00001C20, "overspd");
    rd(ADR_EXT_LIM, 32'h00002710, "ext_lim");
    rd(ADR_STATUS, 32'h17700000, "status");
    rd(ADR_IRQ_MASK, 32'h00000000, "mask");
    wr(8'h24, 32'hFFFFFFFF);
    rd(8'h24, 32'h00000000, "unmapped");
    $display("test reset done");
    // near window: allocation, clamping, strict bound, sign
    err <= 32'h00000005;
    look(0, 0, "near_unalloc");
    wr(ADR_CTRL, 32'h00000001);
    wr(ADR_NEAR_W, 32'h00000000);
    rd(ADR_NEAR_W, 32'h00000001, "near_w_min");
    wr(ADR_NEAR_W, 32'hFFFFFFFF);
    rd(ADR_NEAR_W, 32'h40000000, "near_w_max");
    wr(ADR_NEAR_W, 32'h00000064); // kept above a completed width
    err <= 32'h00000063;
    look(0, 1, "near_99");
    err <= 32'h00000064;
    look(0, 0, "near_100");
    err <= 32'hFFFFFF9D;
    look(0, 1, "near_m99");
    err <= 32'hFFFFFF9C;
    look(0, 0, "near_m100");
    for (int i = 0; i < 8; i++) begin
      rnd = lfsr(rnd);
      e = int'(signed'(rnd[8:0]));
      err <= 32'(e);
      look(0, 32'(e < 100 && e > -100), "near_rand");
    end
    err <= 32'h00000005;
    look(0, 1, "near_in");
    clk_en <= 1'b0;
    err <= 32'h000001F4;
    look(0, 1, "near_frozen");
    clk_en <= 1'b1;
    look(0, 0, "near_out");
    $display("test near done");
    // speed limit selection and limit flag
    wr(ADR_TRQ_LIM, 32'h00004E20);
    rd(ADR_TRQ_LIM, 32'h00002710, "trq_clamp");
    look(3, 32'h00001770, "lim_motor_max");
    wr(ADR_TRQ_LIM, 32'h00001388);
    look(3, 32'h00001388, "lim_5000");
    wr(ADR_TRQ_LIM, 32'h00002710);
    wr(ADR_CTRL, 32'h00000009);
    look(3, 32'h00001770, "lim_staged");
    wr(ADR_CTRL, 32'h00000019);
    look(3, 32'h00001C20, "lim_overspd");
    wr(ADR_CTRL, 32'h00000017);
    look(3, 32'h00002710, "lim_ext_rst");
    wr(ADR_EXT_LIM, 32'h00000BB8);
    look(3, 32'h00000BB8, "lim_ext");
    trq_w <= 1'b1;
    spd <= 16'h0BB7;
    look(1, 0, "vlt_below");
    spd <= 16'h0BB8;
    look(1, 1, "vlt_equal");
    spd <= 16'hF448;
    look(1, 1, "vlt_neg");
    trq_w <= 1'b0;
    look(1, 0, "vlt_no_trq");
    wr(ADR_CTRL, 32'h00000005);
    trq_w <= 1'b1;
    spd <= 16'h0BB8;
    look(1, 0, "vlt_unalloc");
    rd(ADR_STATUS, 32'h0BB80006, "status_raw");
    wr(ADR_CTRL, 32'h00000007);
    trq_w <= 1'b0;
    look(1, 0, "vlt_off");
    $display("test limit done");
    // interrupt: raise, clear, mask
    wr(ADR_IRQ_STAT, 32'h0000000F);
    rd(ADR_IRQ_STAT, 32'h00000000, "irq_clr");
    wr(ADR_IRQ_MASK, 32'h00000001);
    err <= 32'h00000005;
    look(2, 1, "irq_near_rise");
    rd(ADR_IRQ_STAT, 32'h00000001, "irq_stat");
    wr(ADR_IRQ_STAT, 32'h00000001);
    look(2, 0, "irq_w1c");
    wr(ADR_IRQ_MASK, 32'h00000000);
    err <= 32'h000001F4;
    look(2, 0, "irq_masked");
    rd(ADR_IRQ_STAT, 32'h00000002, "irq_fall");
    $display("test irq done");
    close_out();
  end
endmodule
`default_nettype wire
